/* bime_exec.sv */
// execution unit for jump, or-literal, increment, or-file and move-file
// assumes file_rdata already holds file register f of the offered word
// and that program_page_latch comes from logic on the same clock
//
// Summary of operation
// - jump loads the 11-bit immediate into pc bits 10 to 0.
// - jump loads pc bits 12 and 11 from page latch bits 4 and 3.
// - jump takes two instruction cycles and leaves the zero flag alone.
// - or-literal ors the accumulator with k, writes accumulator, updates zero.
// - increment adds one to f, result to accumulator or f by d, updates zero.
// - or-file ors accumulator with f, result routed by d, updates zero.
// - move-file copies f to accumulator or back to f, updates zero.
module bime_exec (
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  input  wire logic                          instr_valid,
  input  wire logic [bime_pkg::INSTR_W-1:0]  instr,
  input  wire logic [bime_pkg::DATA_W-1:0]   file_rdata,
  input  wire logic [bime_pkg::DATA_W-1:0]   program_page_latch,
  output logic                               instr_ready,
  output logic                               retired,
  output logic                               unsupported,
  output logic      [bime_pkg::PC_W-1:0]     pc,
  output logic      [bime_pkg::DATA_W-1:0]   acc,
  output logic                               zero,
  output bime_pkg::bime_fwr_s                file_wr
);
  import bime_pkg::*;

  // *****************************************************************
  // decode
  // *****************************************************************
  bime_dec_s dec;

  bime_decode u_decode (
    .instr (instr),
    .dec   (dec)
  );

  // zero test shared by every flag-updating path
  function automatic logic result_is_zero(input logic [DATA_W-1:0] r);
    return (r == '0);
  endfunction

  // *****************************************************************
  // state
  // *****************************************************************
  bime_state_e         state;
  bime_state_e         next_state;
  logic [PC_W-1:0]     next_pc;
  logic [DATA_W-1:0]   next_acc;
  logic                next_zero;
  logic                next_instr_ready;
  logic                next_retired;
  logic                next_unsupported;
  bime_fwr_s           next_file_wr;
  logic [DATA_W-1:0]   result;
  logic                take;

  assign take = instr_valid && instr_ready;

  // next-state logic; the flush cycle of a jump refuses new words so the
  // stale word fetched behind the jump never executes
  always_comb begin
    next_state       = state;
    next_pc          = pc;
    next_acc         = acc;
    next_zero        = zero;
    next_instr_ready = instr_ready;
    next_retired     = 1'b0;
    next_unsupported = 1'b0;
    next_file_wr     = '0;
    next_file_wr.addr = file_wr.addr;
    next_file_wr.data = file_wr.data;
    result           = '0;
    unique case (state)
      ST_EXEC: begin
        if (take) begin
          if (dec.op == OP_JUMP) begin
            next_pc          = {program_page_latch[PAGE_HI_POS:PAGE_LO_POS], dec.target};
            next_state       = ST_FLUSH;
            next_instr_ready = 1'b0;
          end else begin
            // single-cycle group: retire now and advance pc by one word
            next_pc      = PC_W'(pc + 1'b1);
            next_retired = 1'b1;
            unique case (dec.op)
              OP_OR_LITERAL: result = acc | dec.lit;
              OP_INCREMENT:  result = DATA_W'(file_rdata + 1'b1);
              OP_OR_FILE:    result = acc | file_rdata;
              OP_MOVE_FILE:  result = file_rdata;
              default:       result = '0;
            endcase
            if (dec.op == OP_NONE) begin
              next_unsupported = 1'b1;  // word ignored, nothing written
            end else begin
              next_zero = result_is_zero(result);
              if (dec.op == OP_OR_LITERAL || !dec.dest) begin
                next_acc = result;
              end else begin
                next_file_wr.we   = 1'b1;
                next_file_wr.addr = dec.faddr;
                next_file_wr.data = result;
              end
            end
          end
        end
      end
      ST_FLUSH: begin
        // second cycle of the jump: flags untouched, retire at its end
        next_state       = ST_EXEC;
        next_instr_ready = 1'b1;
        next_retired     = 1'b1;
      end
      default: begin
        next_state       = ST_EXEC;
        next_instr_ready = 1'b1;
      end
    endcase
  end

  // registers; every output comes straight from here
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_EXEC;
      pc          <= PC_RESET;
      acc         <= ACC_RESET;
      zero        <= ZERO_RESET;
      instr_ready <= 1'b1;
      retired     <= 1'b0;
      unsupported <= 1'b0;
      file_wr     <= '0;
    end else begin
      state       <= next_state;
      pc          <= next_pc;
      acc         <= next_acc;
      zero        <= next_zero;
      instr_ready <= next_instr_ready;
      retired     <= next_retired;
      unsupported <= next_unsupported;
      file_wr     <= next_file_wr;
    end
  end

  // *****************************************************************
  // checks
  // *****************************************************************
  // helper copies of the inputs of the word taken last cycle
  logic                h_take;
  bime_dec_s           h_dec;
  logic [DATA_W-1:0]   h_acc;
  logic [DATA_W-1:0]   h_rdata;
  logic [DATA_W-1:0]   h_page;
  logic                h_zero;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      h_take  <= 1'b0;
      h_dec   <= '0;
      h_acc   <= '0;
      h_rdata <= '0;
      h_page  <= '0;
      h_zero  <= 1'b0;
    end else begin
      h_take  <= take && (state == ST_EXEC);
      h_dec   <= dec;
      h_acc   <= acc;
      h_rdata <= file_rdata;
      h_page  <= program_page_latch;
      h_zero  <= zero;
    end
  end

  sequence s_jump_taken;
    take && state == ST_EXEC && dec.op == OP_JUMP;
  endsequence

  sequence s_jump_flush;
    !instr_ready && !retired ##1 instr_ready && retired;
  endsequence

  property p_jump_low;
    @(posedge mclk) disable iff (!reset_n)
      h_take && h_dec.op == OP_JUMP |-> pc[TARGET_W-1:0] == h_dec.target;
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump low pc bits wrong");

  property p_jump_high;
    @(posedge mclk) disable iff (!reset_n)
      h_take && h_dec.op == OP_JUMP |-> pc[PC_W-1:TARGET_W] == h_page[PAGE_HI_POS:PAGE_LO_POS];
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("jump high pc bits wrong");

  property p_jump_two;
    @(posedge mclk) disable iff (!reset_n)
      s_jump_taken |=> s_jump_flush;
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

  property p_jump_flags;
    @(posedge mclk) disable iff (!reset_n)
      s_jump_taken |=> $stable(zero) && !file_wr.we ##1 $stable(zero) && !file_wr.we;
  endproperty
  a_jump_flags: assert property (p_jump_flags) else $error("jump touched zero or file");

  property p_or_literal;
    @(posedge mclk) disable iff (!reset_n)
      h_take && h_dec.op == OP_OR_LITERAL |-> acc == (h_acc | h_dec.lit) && !file_wr.we;
  endproperty
  a_or_literal: assert property (p_or_literal) else $error("or literal result wrong");

  property p_increment;
    @(posedge mclk) disable iff (!reset_n)
      h_take && h_dec.op == OP_INCREMENT |->
        (h_dec.dest ? (file_wr.we && file_wr.data == DATA_W'(h_rdata + 1'b1) && acc == h_acc)
                    : (!file_wr.we && acc == DATA_W'(h_rdata + 1'b1)));
  endproperty
  a_increment: assert property (p_increment) else $error("increment result wrong");

  property p_or_file;
    @(posedge mclk) disable iff (!reset_n)
      h_take && h_dec.op == OP_OR_FILE |->
        (h_dec.dest ? (file_wr.we && file_wr.addr == h_dec.faddr && file_wr.data == (h_acc | h_rdata))
                    : (!file_wr.we && acc == (h_acc | h_rdata)));
  endproperty
  a_or_file: assert property (p_or_file) else $error("or file result wrong");

  property p_move_file;
    @(posedge mclk) disable iff (!reset_n)
      h_take && h_dec.op == OP_MOVE_FILE |->
        (h_dec.dest ? (file_wr.we && file_wr.data == h_rdata) : (acc == h_rdata)) && zero == (h_rdata == '0);
  endproperty
  a_move_file: assert property (p_move_file) else $error("move file result wrong");

  property p_move_one_cycle;
    @(posedge mclk) disable iff (!reset_n)
      take && state == ST_EXEC && dec.op == OP_MOVE_FILE |=> retired && instr_ready;
  endproperty
  a_move_one_cycle: assert property (p_move_one_cycle) else $error("move file not single cycle");

  property p_zero_flag;
    @(posedge mclk) disable iff (!reset_n)
      h_take && h_dec.op != OP_JUMP && h_dec.op != OP_NONE |->
        zero == ((h_dec.op == OP_OR_LITERAL || !h_dec.dest) ? (acc == '0) : (file_wr.data == '0));
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag disagrees with result");

  property p_unsupported_quiet;
    @(posedge mclk) disable iff (!reset_n)
      h_take && h_dec.op == OP_NONE |-> unsupported && !file_wr.we && acc == h_acc && zero == h_zero;
  endproperty
  a_unsupported_quiet: assert property (p_unsupported_quiet) else $error("ignored word changed state");

endmodule

/* bime_pkg.sv */
// package for the branch / or / increment / move execution block
// assumes 14-bit instruction words and an 8-bit file register datapath
package bime_pkg;

  // *****************************************************************
  // widths
  // *****************************************************************
  localparam int unsigned INSTR_W  = 14;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned FADDR_W  = 7;
  localparam int unsigned TARGET_W = 11;
  localparam int unsigned PC_W     = 13;

  // *****************************************************************
  // instruction field positions
  // *****************************************************************
  localparam int unsigned DEST_POS     = 7;   // d bit
  localparam int unsigned PAGE_LO_POS  = 3;   // page latch bits 4:3 feed pc 12:11
  localparam int unsigned PAGE_HI_POS  = 4;

  // *****************************************************************
  // opcode patterns
  // *****************************************************************
  localparam logic [2:0] OPC_JUMP_ABSOLUTE       = 3'h5;   // instr[13:11]
  localparam logic [5:0] OPC_OR_LITERAL_INTO_ACC = 6'h38;  // instr[13:8]
  localparam logic [5:0] OPC_INCREMENT_FILE_REG  = 6'h0A;
  localparam logic [5:0] OPC_OR_ACC_WITH_FILE    = 6'h04;
  localparam logic [5:0] OPC_MOVE_FILE_REG       = 6'h08;

  // *****************************************************************
  // reset values
  // *****************************************************************
  localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic              ZERO_RESET = 1'b0;

  // *****************************************************************
  // types
  // *****************************************************************
  typedef enum logic [5:0] {
    OP_NONE        = 6'h01,
    OP_JUMP        = 6'h02,
    OP_OR_LITERAL  = 6'h04,
    OP_INCREMENT   = 6'h08,
    OP_OR_FILE     = 6'h10,
    OP_MOVE_FILE   = 6'h20
  } bime_op_e;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'h1,
    ST_FLUSH = 2'h2
  } bime_state_e;

  typedef struct packed {
    bime_op_e              op;
    logic                  dest;
    logic [FADDR_W-1:0]    faddr;
    logic [DATA_W-1:0]     lit;
    logic [TARGET_W-1:0]   target;
  } bime_dec_s;

  typedef struct packed {
    logic                  we;
    logic [FADDR_W-1:0]    addr;
    logic [DATA_W-1:0]     data;
  } bime_fwr_s;

endpackage

/* bime_decode.sv */
// instruction decoder for the execution block
// assumes a stable instruction word from the fetch path; purely combinational
module bime_decode (
  input  wire logic [bime_pkg::INSTR_W-1:0] instr,
  output bime_pkg::bime_dec_s               dec
);
  import bime_pkg::*;

  // *****************************************************************
  // field split and opcode match
  // *****************************************************************
  // operand fields are always split out; only op decides what is used
  always_comb begin
    dec        = '0;
    dec.op     = OP_NONE;
    dec.dest   = instr[DEST_POS];
    dec.faddr  = instr[FADDR_W-1:0];
    dec.lit    = instr[DATA_W-1:0];
    dec.target = instr[TARGET_W-1:0];
    if (instr[13:11] == OPC_JUMP_ABSOLUTE) begin
      dec.op = OP_JUMP;
    end else begin
      unique case (instr[13:8])
        OPC_OR_LITERAL_INTO_ACC: dec.op = OP_OR_LITERAL;
        OPC_INCREMENT_FILE_REG:  dec.op = OP_INCREMENT;
        OPC_OR_ACC_WITH_FILE:    dec.op = OP_OR_FILE;
        OPC_MOVE_FILE_REG:       dec.op = OP_MOVE_FILE;
        default:                 dec.op = OP_NONE;  // other opcodes are not ours
      endcase
    end
  end

endmodule

/* bime_file_model.sv */
// partner model: the file register datapath behind the execution block
// assumes the fetch side presents the f field on faddr for the whole cycle
module bime_file_model (
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic [bime_pkg::FADDR_W-1:0] faddr,
  input  bime_pkg::bime_fwr_s               file_wr,
  output logic      [bime_pkg::DATA_W-1:0]  file_rdata
);
  import bime_pkg::*;

  // ***************************************************************
  // register file storage
  // ***************************************************************
  logic [DATA_W-1:0] mem [128];

  // read is combinational so the operand is valid in the offer cycle
  assign file_rdata = mem[faddr];

  // reset preload {a[0], a}: gives 8'hFF at 7'h7F for the wrap case
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int a = 0; a < 128; a++) begin
        mem[a] <= {a[0], a[6:0]};
      end
    end else if (file_wr.we) begin
      mem[file_wr.addr] <= file_wr.data;  // write lands at the edge ending the pulse
    end
  end
endmodule

/* tb_branch_or_inc_move_exec.sv */
// self-checking bench for the jump / or / increment / move execution block
// assumes the file model preload {a[0], a}; inputs change on the falling edge
module tb_branch_or_inc_move_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import bime_pkg::*;

  // ***************************************************************
  // signals
  // ***************************************************************
  logic                mclk;
  logic                reset_n;
  logic                instr_valid;
  logic [INSTR_W-1:0]  instr;
  logic [DATA_W-1:0]   file_rdata;
  logic [DATA_W-1:0]   page_latch;
  logic                instr_ready;
  logic                retired;
  logic                unsupported;
  logic [PC_W-1:0]     pc;
  logic [DATA_W-1:0]   acc;
  logic                zero;
  bime_fwr_s           file_wr;
  int                  error_cnt;
  int                  comparisons;

  typedef struct {
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0]  acc;
    logic               zero;
    logic               we;
    logic [FADDR_W-1:0] waddr;
    logic [DATA_W-1:0]  wdata;
  } bime_row_s;

  // rows run in order: each expectation follows from the rows before it
  bime_row_s rows [10] = '{
    '{14'h3800, 8'h00, 1'b1, 1'b0, 7'h00, 8'h00},   // or literal 0: zero set
    '{14'h385A, 8'h5A, 1'b0, 1'b0, 7'h00, 8'h00},
    '{14'h0A7F, 8'h00, 1'b1, 1'b0, 7'h00, 8'h00},   // ff + 1 wraps to 0
    '{14'h0AFF, 8'h00, 1'b1, 1'b1, 7'h7F, 8'h00},
    '{14'h0AFF, 8'h00, 1'b0, 1'b1, 7'h7F, 8'h01},   // sees the written value
    '{14'h0401, 8'h81, 1'b0, 1'b0, 7'h00, 8'h00},
    '{14'h04A0, 8'h81, 1'b0, 1'b1, 7'h20, 8'hA1},
    '{14'h0800, 8'h00, 1'b1, 1'b0, 7'h00, 8'h00},
    '{14'h08A0, 8'h00, 1'b0, 1'b1, 7'h20, 8'hA1},
    '{14'h0800, 8'h00, 1'b1, 1'b0, 7'h00, 8'h00}
  };
  logic [DATA_W-1:0]   jl [2] = '{8'h18, 8'hE7};
  logic [TARGET_W-1:0] jk [2] = '{11'h7FF, 11'h400};
  logic [PC_W-1:0]     jp [2] = '{13'h1FFF, 13'h0400};

  // ***************************************************************
  // design and partner
  // ***************************************************************
  bime_exec bime_exec_inst (
    .mclk(mclk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .program_page_latch(page_latch), .instr_ready(instr_ready),
    .retired(retired), .unsupported(unsupported), .pc(pc), .acc(acc), .zero(zero),
    .file_wr(file_wr)
  );

  bime_file_model bime_file_model_inst (
    .mclk(mclk), .reset_n(reset_n), .faddr(instr[FADDR_W-1:0]), .file_wr(file_wr),
    .file_rdata(file_rdata)
  );

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one word with an idle cycle before it, so a write lands before the next read
  task automatic issue(input logic [INSTR_W-1:0] w);
    int n;
    n = 0;
    @(negedge mclk);
    while (instr_ready !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    if (instr_ready !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    instr_valid = 1'b1;
    instr = w;
    @(negedge mclk);
    instr_valid = 1'b0;
  endtask

  // ***************************************************************
  // clock, watchdog and main sequence
  // ***************************************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // cuts a hang short well inside the cycle budget
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end

  initial begin
    error_cnt = 0;
    comparisons = 0;
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    page_latch = 8'h00;
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    chk(16'(pc), 16'h0000);
    chk(16'({acc, zero, instr_ready}), 16'h0001);
    // ordinary cases
    for (int i = 0; i < 10; i++) begin
      issue(rows[i].instr);
      chk(16'(retired), 16'h0001);
      chk(16'(acc), 16'(rows[i].acc));
      chk(16'(zero), 16'(rows[i].zero));
      chk(16'(file_wr.we), 16'(rows[i].we));
      if (rows[i].we) begin
        chk(16'({file_wr.addr, file_wr.data}), 16'({rows[i].waddr, rows[i].wdata}));
      end
      chk(16'(pc), 16'(i + 1));
    end
    // jump: a word offered in the bubble is refused, other latch bits ignored
    for (int j = 0; j < 2; j++) begin
      @(negedge mclk);
      page_latch = jl[j];
      instr_valid = 1'b1;
      instr = {OPC_JUMP_ABSOLUTE, jk[j]};
      @(negedge mclk);
      instr = 14'h38FF;
      page_latch = ~jl[j];
      chk(16'(pc), 16'(jp[j]));
      chk(16'({instr_ready, retired}), 16'h0000);
      @(negedge mclk);
      instr_valid = 1'b0;
      chk(16'({acc, zero}), 16'h0001);
      chk(16'({instr_ready, retired}), 16'h0003);
      chk(16'(pc), 16'(jp[j]));
    end
    // unknown opcode: only the pc moves
    issue(14'h3FFF);
    chk(16'({unsupported, file_wr.we}), 16'h0002);
    chk(16'({acc, zero}), 16'h0001);
    chk(16'(pc), 16'h0401);
    // reset in mid-run acts without a clock edge
    issue(14'h383C);
    chk(16'({acc, zero}), 16'h0078);
    // jump with the zero flag clear: a flag forced to one would slip past the jumps above
    issue(14'h2A55);
    chk(16'({instr_ready, file_wr.we}), 16'h0000);
    @(negedge mclk);
    chk(16'({acc, zero, retired}), 16'h00F1);
    chk(16'(pc), 16'h1A55);
    @(negedge mclk);
    reset_n = 1'b0;
    #1;
    chk(16'(pc), 16'h0000);
    chk(16'({acc, zero, instr_ready}), 16'h0001);
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    chk(16'(pc), 16'h0000);
    chk(16'({acc, zero, instr_ready, retired}), 16'h0002);
    end_sim();
  end
endmodule
